// >>> rtl/mcx_exec.v
// Purpose: executes a subset of the microcore instruction set
// Assumes: one core (a or b) per instance; SPI-side registers reached
//   by a simple word port at their printed addresses
// Notes: multiply and shift operations stall the fetch through instr_ready
//   register-count shifts clamp at 31 cycles
//   the immediate operand register holds zero; no loader lives here
//   a handler exit and a subroutine return in one cycle: exit wins
`timescale 1ns/10ps
`default_nettype none
`include "mcx_map.vh"
module mcx_exec #(
  parameter [8:0] CTRL0_ADDR = `MCX_ADDR_CTRL_A0,
  parameter [8:0] CTRL1_ADDR = `MCX_ADDR_CTRL_A1,
  parameter [8:0] START_ADDR = `MCX_ADDR_START_A,
  parameter [8:0] STAT0_ADDR = `MCX_ADDR_STAT_A0,
  parameter [8:0] STAT1_ADDR = `MCX_ADDR_STAT_A1,
  parameter [8:0] IRQRET_ADDR = `MCX_ADDR_IRQRET_A,
  parameter PC_W = 10
) (
  input wire clk_sys,
  input wire reset_n,
  input wire [15:0] instr_word,
  input wire instr_valid,
  output wire instr_ready,
  input wire [PC_W-1:0] program_counter,
  input wire [PC_W-1:0] return_link,
  output reg [PC_W-1:0] pc_load_value,
  output reg pc_load,
  input wire hw_irq_req,
  input wire irq_handler_done,
  output reg soft_irq_active_q,
  output reg [1:0] soft_irq_number,
  output reg soft_irq_pulse,
  output wire hw_irq_accept,
  input wire [PC_W-1:0] hw_irq_pc,
  input wire [8:0] spi_address,
  input wire spi_address_write,
  output reg backdoor_read_pulse,
  output reg [8:0] backdoor_addr,
  output reg backdoor_corrupt,
  output reg diag_irq_rearm,
  input wire [8:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_write,
  output reg [15:0] reg_rdata,
  input wire [15:0] start_latch_set,
  output reg [15:0] start_latch_q,
  input wire [15:0] stat_set0,
  input wire [15:0] stat_set1,
  input wire [15:0] diag_set,
  input wire [2:0] diag_index,
  output reg [15:0] product_high_half,
  output reg [15:0] product_low_half,
  output reg shift_overflow_flag,
  output reg precision_loss_flag,
  output reg operation_done_flag,
  output reg mask_zero_flag,
  output reg mask_all_ones_flag,
  output reg shifted_out_bit_flag
);

////////////////////////////////////////////////////////////////////////
localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_MUL = 2'h1;
localparam [1:0] ST_SHL = 2'h2;
localparam [1:0] ST_SHR = 2'h3;

// Bit positions of the decoded clear target
localparam TGT_STAT = 0;
localparam TGT_CTRL = 1;
localparam TGT_DIAG = 2;
localparam TGT_REARM = 3;

reg [15:0] gpr_q [0:7];
reg [15:0] immediate_operand_register;

reg [15:0] ctrl0_q;
reg [15:0] ctrl1_q;
reg [15:0] start_cfg_q;
reg [15:0] stat0_q;
reg [15:0] stat1_q;
reg [15:0] irqret_q;
reg [15:0] diag_q [0:7];

reg [1:0] state_q;
reg [4:0] count_q;
reg [31:0] mul_a_q;
reg [15:0] mul_b_q;
reg [31:0] acc_q;
reg rd_pend_q;
integer i;

wire [2:0] sel = instr_word[2:0];
wire [2:0] sel_sh = instr_word[5:3];
wire [3:0] imm4 = instr_word[6:3];
wire [2:0] clear_target_field = instr_word[2:0];
wire [31:0] product_pair = {product_high_half, product_low_half};
wire busy = (state_q != ST_IDLE);
wire go = instr_valid && !busy;

assign instr_ready = !busy;

wire is_muli = go && instr_word[15:7] == `MCX_OP_MULI;
wire is_not = go && instr_word[15:3] == `MCX_OP_NOT;
wire is_or = go && instr_word[15:3] == `MCX_OP_OR;
wire is_rdspi = go && instr_word == `MCX_OP_RDSPI;
wire is_reqi = go && instr_word[15:3] == `MCX_OP_REQI;
wire is_rfs = go && instr_word == `MCX_OP_RFS;
wire is_rstreg = go && instr_word[15:3] == `MCX_OP_RSTREG;
wire is_rstsl = go && instr_word == `MCX_OP_RSTSL;
wire is_shl_reg = go && instr_word[15:6] == `MCX_OP_SHL_REG &&
  instr_word[2:0] == `MCX_OP_SH_TAIL;
wire is_shl_c = go && instr_word[15:7] == `MCX_OP_SHL_CONST &&
  instr_word[2:0] == `MCX_OP_SH_TAIL;
wire is_shr_reg = go && instr_word[15:6] == `MCX_OP_SHR_REG &&
  instr_word[2:0] == `MCX_OP_SH_TAIL;

// Target decode: status, control, diagnosis, rearm
function [3:0] tgt_dec;
  input [2:0] t;
  begin
    case (t)
      3'h0: tgt_dec = 4'h1;
      3'h1: tgt_dec = 4'h2;
      3'h2: tgt_dec = 4'hD;
      3'h3: tgt_dec = 4'hF;
      3'h4: tgt_dec = 4'hC;
      3'h5: tgt_dec = 4'h3;
      3'h6: tgt_dec = 4'h9;
      default: tgt_dec = 4'h8;
    endcase
  end
endfunction

function [15:0] clamp_cnt;
  input [15:0] v;
  begin
    clamp_cnt = (v > 16'h001F) ? 16'h001F : v;
  end
endfunction

// All-ones and zero mask flags of a result
function [1:0] mask_of;
  input [15:0] r;
  begin
    mask_of = {(r == 16'hFFFF), (r == 16'h0000)};
  end
endfunction

wire [3:0] tgt = is_rstreg ? tgt_dec(clear_target_field) : 4'h0;
wire [15:0] not_res = ~gpr_q[sel];
wire [15:0] or_res = gpr_q[sel] | immediate_operand_register;
wire [15:0] shl_cnt = clamp_cnt(gpr_q[sel_sh]);
wire sw_irq_block = soft_irq_active_q || is_reqi;
assign hw_irq_accept = hw_irq_req && !sw_irq_block;

////////////////////////////////////////////////////////////////////////
// Execution and multi-cycle engine
always @(posedge clk_sys or negedge reset_n) begin
  if (!reset_n) begin
    for (i = 0; i < 8; i = i + 1) begin
      gpr_q[i] <= `MCX_RESET_WORD;
    end
    immediate_operand_register <= `MCX_RESET_WORD;
    state_q <= ST_IDLE;
    count_q <= 5'h00;
    mul_a_q <= 32'h00000000;
    mul_b_q <= 16'h0000;
    acc_q <= 32'h00000000;
    product_high_half <= 16'h0000;
    product_low_half <= 16'h0000;
    shift_overflow_flag <= 1'b0;
    precision_loss_flag <= 1'b0;
    operation_done_flag <= 1'b0;
    mask_zero_flag <= 1'b0;
    mask_all_ones_flag <= 1'b0;
    shifted_out_bit_flag <= 1'b0;
  end else begin
    if (is_not) begin
      gpr_q[sel] <= not_res;
      {mask_all_ones_flag, mask_zero_flag} <= mask_of(not_res);
    end
    if (is_or) begin
      gpr_q[sel] <= or_res;
      {mask_all_ones_flag, mask_zero_flag} <= mask_of(or_res);
    end
    case (state_q)
      ST_IDLE: begin
        if (is_muli) begin
          mul_a_q <= {16'h0000, gpr_q[sel]};
          mul_b_q <= {12'h000, imm4};
          acc_q <= 32'h00000000;
          count_q <= `MCX_MUL_CYCLES;
          operation_done_flag <= 1'b0;
          state_q <= ST_MUL;
        end else if ((is_shl_reg || is_shr_reg) && shl_cnt != 16'h0000) begin
          count_q <= shl_cnt[4:0];
          shifted_out_bit_flag <= 1'b0;
          state_q <= is_shl_reg ? ST_SHL : ST_SHR;
        end else if (is_shl_c && imm4 != 4'h0) begin
          count_q <= {1'b0, imm4};
          shifted_out_bit_flag <= 1'b0;
          state_q <= ST_SHL;
        end
      end
      ST_MUL: begin
        // Shift-and-add: 16 add steps then one commit cycle
        if (count_q > 5'h01) begin
          if (mul_b_q[0])
            acc_q <= acc_q + mul_a_q;
          mul_a_q <= {mul_a_q[30:0], 1'b0};
          mul_b_q <= {1'b0, mul_b_q[15:1]};
          count_q <= count_q - 5'h01;
        end else begin
          product_high_half <= acc_q[31:16];
          product_low_half <= acc_q[15:0];
          shift_overflow_flag <= 1'b0; // 16x4 bits never overflow
          precision_loss_flag <= 1'b0;
          operation_done_flag <= 1'b1;
          count_q <= 5'h00;
          state_q <= ST_IDLE;
        end
      end
      ST_SHL: begin
        {product_high_half, product_low_half} <= {product_pair[30:0], 1'b0};
        shifted_out_bit_flag <= product_pair[31];
        if (product_pair[31])
          shift_overflow_flag <= 1'b1;
        count_q <= count_q - 5'h01;
        if (count_q == 5'h01)
          state_q <= ST_IDLE;
      end
      default: begin
        {product_high_half, product_low_half} <= {1'b0, product_pair[31:1]};
        shifted_out_bit_flag <= product_pair[0];
        if (product_pair[0])
          precision_loss_flag <= 1'b1;
        count_q <= count_q - 5'h01;
        if (count_q == 5'h01)
          state_q <= ST_IDLE;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// Backdoor read, interrupts and returns
always @(posedge clk_sys or negedge reset_n) begin
  if (!reset_n) begin
    rd_pend_q <= 1'b0;
    backdoor_read_pulse <= 1'b0;
    backdoor_addr <= 9'h000;
    backdoor_corrupt <= 1'b0;
    soft_irq_active_q <= 1'b0;
    soft_irq_number <= 2'h0;
    soft_irq_pulse <= 1'b0;
    pc_load <= 1'b0;
    pc_load_value <= {PC_W{1'b0}};
    irqret_q <= 16'h0000;
  end else begin
    backdoor_read_pulse <= 1'b0;
    soft_irq_pulse <= 1'b0;
    pc_load <= 1'b0;
    rd_pend_q <= is_rdspi;
    if (is_rdspi) begin
      backdoor_addr <= spi_address;
      backdoor_corrupt <= 1'b0;
    end
    if (rd_pend_q) begin
      backdoor_read_pulse <= 1'b1;
      backdoor_corrupt <= spi_address_write;
    end
    if (is_reqi) begin
      irqret_q[PC_W-1:0] <= program_counter;
      soft_irq_number <= instr_word[1:0];
      soft_irq_pulse <= 1'b1;
      soft_irq_active_q <= 1'b1;
    end else if (soft_irq_active_q && irq_handler_done) begin
      soft_irq_active_q <= 1'b0;
    end else if (hw_irq_accept) begin
      irqret_q[PC_W-1:0] <= hw_irq_pc;
    end else if (reg_write && reg_addr == IRQRET_ADDR) begin
      irqret_q <= reg_wdata;
    end
    // Kept apart so an accepted hardware interrupt cannot drop a return
    if (soft_irq_active_q && irq_handler_done) begin
      pc_load <= 1'b1;
      pc_load_value <= irqret_q[PC_W-1:0] + 1'b1;
    end else if (is_rfs) begin
      pc_load <= 1'b1;
      pc_load_value <= return_link;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// SPI-side registers; hardware set wins over instruction clear
always @(posedge clk_sys or negedge reset_n) begin
  if (!reset_n) begin
    ctrl0_q <= 16'h0000;
    ctrl1_q <= 16'h0000;
    start_cfg_q <= 16'h0000;
    stat0_q <= 16'h0000;
    stat1_q <= 16'h0000;
    start_latch_q <= 16'h0000;
    diag_irq_rearm <= 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      diag_q[i] <= 16'h0000;
    end
  end else begin
    diag_irq_rearm <= tgt[TGT_REARM];
    if (tgt[TGT_CTRL]) begin
      ctrl0_q <= 16'h0000;
      ctrl1_q <= 16'h0000;
    end else if (reg_write && reg_addr == CTRL0_ADDR) begin
      ctrl0_q <= reg_wdata;
    end else if (reg_write && reg_addr == CTRL1_ADDR) begin
      ctrl1_q <= reg_wdata;
    end
    if (reg_write && reg_addr == START_ADDR) begin
      start_cfg_q <= reg_wdata;
    end
    stat0_q <= (tgt[TGT_STAT] ? 16'h0000 : stat0_q) | stat_set0;
    stat1_q <= (tgt[TGT_STAT] ? 16'h0000 : stat1_q) | stat_set1;
    for (i = 0; i < 8; i = i + 1)
      diag_q[i] <= (tgt[TGT_DIAG] ? 16'h0000 : diag_q[i]) |
        ((diag_index == i[2:0]) ? diag_set : 16'h0000);
    start_latch_q <= ((is_rstsl && start_cfg_q[`MCX_LATCH_EN_BIT]) ?
      16'h0000 : start_latch_q) | start_latch_set;
  end
end

always @* begin
  reg_rdata = 16'h0000;
  if (reg_addr == CTRL0_ADDR) reg_rdata = ctrl0_q;
  else if (reg_addr == CTRL1_ADDR) reg_rdata = ctrl1_q;
  else if (reg_addr == START_ADDR) reg_rdata = start_cfg_q;
  else if (reg_addr == STAT0_ADDR) reg_rdata = stat0_q;
  else if (reg_addr == STAT1_ADDR) reg_rdata = stat1_q;
  else if (reg_addr == IRQRET_ADDR) reg_rdata = irqret_q;
  else if (reg_addr >= `MCX_ADDR_DIAG_LO && reg_addr <= `MCX_ADDR_DIAG_HI)
    reg_rdata = diag_q[reg_addr[2:0] - 3'h2];
end

endmodule
`default_nettype wire

// >>> rtl/mcx_map.vh
// Purpose: constants for the microcore instruction subset executor
// Assumes: 16-bit instruction words, register addresses as 9-bit indexes
// Notes: opcode patterns compared against upper instruction bits or, for RDSPI, RFS and RSTSL, the whole word; the shift tail against bits 2:0
`ifndef MCX_MAP_VH
`define MCX_MAP_VH
`define MCX_OP_MULI 9'h04E
`define MCX_OP_NOT 13'h05DB
`define MCX_OP_OR 13'h05D8
`define MCX_OP_RDSPI 16'h3540
`define MCX_OP_REQI 13'h06B1
`define MCX_OP_RFS 16'h359C
`define MCX_OP_RSTREG 13'h06A9
`define MCX_OP_RSTSL 16'h359D
`define MCX_OP_SHL_REG 10'h0E5
`define MCX_OP_SHL_CONST 9'h071
`define MCX_OP_SHR_REG 10'h0E4
`define MCX_OP_SH_TAIL 3'h5
`define MCX_ADDR_CTRL_A0 9'h101
`define MCX_ADDR_CTRL_A1 9'h102
`define MCX_ADDR_START_A 9'h104
`define MCX_ADDR_STAT_A0 9'h105
`define MCX_ADDR_STAT_A1 9'h106
`define MCX_ADDR_IRQRET_A 9'h10F
`define MCX_ADDR_CTRL_B0 9'h121
`define MCX_ADDR_CTRL_B1 9'h122
`define MCX_ADDR_START_B 9'h124
`define MCX_ADDR_STAT_B0 9'h125
`define MCX_ADDR_STAT_B1 9'h126
`define MCX_ADDR_IRQRET_B 9'h12F
`define MCX_ADDR_DIAG_LO 9'h162
`define MCX_ADDR_DIAG_HI 9'h169
`define MCX_RESET_WORD 16'h0000
`define MCX_MUL_CYCLES 5'h11
`define MCX_RDSPI_CYCLES 2'h2
`define MCX_LATCH_EN_BIT 0
`endif

// >>> dv/mcx_exec_sva.sv
// Purpose: port assertions for the instruction subset executor
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to the design from the testbench top file
`timescale 1ns/10ps
`default_nettype none
`include "mcx_map.vh"
module mcx_exec_sva #(
  parameter PC_W = 10
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [PC_W-1:0] return_link,
  input wire logic [PC_W-1:0] pc_load_value,
  input wire logic pc_load,
  input wire logic hw_irq_accept,
  input wire logic irq_handler_done,
  input wire logic soft_irq_active_q,
  input wire logic [1:0] soft_irq_number,
  input wire logic soft_irq_pulse,
  input wire logic [8:0] spi_address,
  input wire logic spi_address_write,
  input wire logic backdoor_read_pulse,
  input wire logic [8:0] backdoor_addr,
  input wire logic backdoor_corrupt,
  input wire logic operation_done_flag
);
  logic tk;
  assign tk = instr_valid && instr_ready;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  AST_RDSPI_ADDR: assert property (tk && instr_word == `MCX_OP_RDSPI
    |=> backdoor_addr == $past(spi_address)) else $error("bad bd addr");
  AST_RDSPI_DONE: assert property (tk && instr_word == `MCX_OP_RDSPI
    |-> ##2 backdoor_read_pulse) else $error("bd read late");
  AST_RDSPI_FAIL: assert property (tk && instr_word == `MCX_OP_RDSPI
    ##1 spi_address_write |-> ##[1:2] backdoor_corrupt)
    else $error("corrupt missing");
  AST_MUL_TIME: assert property (tk && instr_word[15:7] == `MCX_OP_MULI
    |=> !instr_ready ##15 !instr_ready ##[1:2]
    (instr_ready && operation_done_flag)) else $error("mul timing");
  AST_SHL_ONE: assert property (tk && instr_word == 16'h388D
    |=> !instr_ready ##1 instr_ready) else $error("shift timing");
  AST_SOFT_ENTRY: assert property (tk && instr_word[15:2] == 14'h0D62
    |=> soft_irq_pulse && soft_irq_active_q
    && soft_irq_number == $past(instr_word[1:0])) else $error("soft entry");
  AST_NO_PREEMPT: assert property (soft_irq_active_q
    |-> !hw_irq_accept) else $error("soft handler preempted");
  AST_SOFT_RETURN: assert property (soft_irq_active_q && irq_handler_done
    |=> pc_load) else $error("no soft return");
  AST_RFS_LOAD: assert property (tk && instr_word == `MCX_OP_RFS
    |=> pc_load && pc_load_value == $past(return_link))
    else $error("bad return load");
endmodule
`default_nettype wire

// >>> dv/mcx_exec_tb_top.sv
// Purpose: self-checking bench for the instruction subset executor
// Assumes: core a addresses, default parameters
// Notes: program counter loads are scored from an expectation queue
`timescale 1ns/10ps
`default_nettype none
`include "mcx_map.vh"
module mcx_exec_tb_top;
  localparam logic [7:0] CLR_CTRL = 8'h2A, CLR_STAT = 8'h6D;
  localparam logic [7:0] CLR_DIAG = 8'h1C, REARM = 8'hDC;
  logic clk_sys = 1'b0, reset_n = 1'b0, instr_valid = 1'b0;
  logic hw_irq_req = 1'b0, irq_handler_done = 1'b0;
  logic spi_address_write = 1'b0, reg_write = 1'b0;
  logic [15:0] instr_word = 16'h0000, reg_wdata = 16'h0000;
  logic [15:0] start_latch_set = 16'h0000, diag_set = 16'h0000;
  logic [15:0] stat_set0 = 16'h0000, stat_set1 = 16'h0000;
  logic [9:0] program_counter = 10'h000, return_link = 10'h000;
  logic [9:0] hw_irq_pc = 10'h000, pc_load_value;
  logic [8:0] spi_address = 9'h000, reg_addr = 9'h000, backdoor_addr;
  logic [2:0] diag_index = 3'h0;
  logic [1:0] soft_irq_number;
  logic instr_ready, pc_load, soft_irq_active_q, soft_irq_pulse;
  logic hw_irq_accept, backdoor_read_pulse, backdoor_corrupt;
  logic diag_irq_rearm, shift_overflow_flag, precision_loss_flag;
  logic operation_done_flag, mask_zero_flag, mask_all_ones_flag;
  logic shifted_out_bit_flag;
  logic [15:0] reg_rdata, start_latch_q, product_high_half;
  logic [15:0] product_low_half, v, sm, dm;
  logic [31:0] pe;
  logic [9:0] exp_q[$];
  logic [3:0] n;
  int num_errors = 0, samples_checked = 0, seed = 97547;
  mcx_exec dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .instr_word(instr_word), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .program_counter(program_counter),
    .return_link(return_link), .pc_load_value(pc_load_value),
    .pc_load(pc_load), .hw_irq_req(hw_irq_req),
    .irq_handler_done(irq_handler_done),
    .soft_irq_active_q(soft_irq_active_q),
    .soft_irq_number(soft_irq_number), .soft_irq_pulse(soft_irq_pulse),
    .hw_irq_accept(hw_irq_accept), .hw_irq_pc(hw_irq_pc),
    .spi_address(spi_address), .spi_address_write(spi_address_write),
    .backdoor_read_pulse(backdoor_read_pulse),
    .backdoor_addr(backdoor_addr), .backdoor_corrupt(backdoor_corrupt),
    .diag_irq_rearm(diag_irq_rearm), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
    .start_latch_set(start_latch_set), .start_latch_q(start_latch_q),
    .stat_set0(stat_set0), .stat_set1(stat_set1), .diag_set(diag_set),
    .diag_index(diag_index), .product_high_half(product_high_half),
    .product_low_half(product_low_half),
    .shift_overflow_flag(shift_overflow_flag),
    .precision_loss_flag(precision_loss_flag),
    .operation_done_flag(operation_done_flag),
    .mask_zero_flag(mask_zero_flag),
    .mask_all_ones_flag(mask_all_ones_flag),
    .shifted_out_bit_flag(shifted_out_bit_flag));
  always #10 clk_sys = ~clk_sys;
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task tick;
    @(posedge clk_sys);
    #1;
  endtask
  task exec(input logic [15:0] w);
    instr_word = w;
    instr_valid = 1'b1;
    tick;
    instr_valid = 1'b0;
  endtask
  task wr(input logic [8:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    tick;
    reg_write = 1'b0;
  endtask
  task rd(input logic [8:0] a, input logic [15:0] e, input string nm);
    reg_addr = a;
    #1;
    check(nm, reg_rdata, e);
  endtask
  task automatic stall(input int cnt, input string nm);
    int c;
    c = 0;
    while (instr_ready !== 1'b1 && c < 100) begin
      tick;
      c++;
    end
    check(nm, c[15:0], cnt[15:0]);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scoreboard for program counter loads
  always @(posedge clk_sys) begin
    if (reset_n && pc_load === 1'b1) begin
      if (exp_q.size() == 0) check("spare pc load", 16'h0001, 16'h0000);
      else check("pc load", {6'h00, pc_load_value}, {6'h00, exp_q.pop_front()});
    end
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    tally_and_finish;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    check("ready after reset", {15'h0000, instr_ready}, 16'h0001);
    sm = 16'h0000;
    dm = 16'h0000;
    diag_index = 3'($random(seed));
    for (int t = 0; t < 8; t++) begin
      v = $random(seed);
      wr(`MCX_ADDR_CTRL_A0, v);
      stat_set0 = v;
      stat_set1 = v;
      diag_set = v;
      tick;
      {stat_set0, stat_set1, diag_set} = 48'h0;
      sm = sm | v;
      dm = dm | v;
      exec({`MCX_OP_RSTREG, 3'(t)});
      check("rearm", {15'h0000, diag_irq_rearm}, {15'h0000, REARM[t]});
      rd(`MCX_ADDR_CTRL_A0, CLR_CTRL[t] ? 16'h0000 : v, "ctrl");
      if (CLR_STAT[t]) sm = 16'h0000;
      rd(`MCX_ADDR_STAT_A0, sm, "stat0");
      rd(`MCX_ADDR_STAT_A1, sm, "stat1");
      if (CLR_DIAG[t]) dm = 16'h0000;
      rd(`MCX_ADDR_DIAG_LO + {6'h00, diag_index}, dm, "diag");
    end
    start_latch_set = v | 16'h0001;
    tick;
    start_latch_set = 16'h0000;
    exec(`MCX_OP_RSTSL);
    check("latch kept", start_latch_q, v | 16'h0001);
    wr(`MCX_ADDR_START_A, 16'h0001);
    exec(`MCX_OP_RSTSL);
    check("latch cleared", start_latch_q, 16'h0000);
    spi_address = v[8:0];
    exec(`MCX_OP_RDSPI);
    check("bd addr", {7'h00, backdoor_addr}, {7'h00, v[8:0]});
    tick;
    check("bd pulse", {15'h0000, backdoor_read_pulse}, 16'h0001);
    exec(`MCX_OP_RDSPI);
    spi_address = ~v[8:0];
    spi_address_write = 1'b1;
    tick;
    spi_address_write = 1'b0;
    tick;
    check("bd corrupt", {15'h0000, backdoor_corrupt}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      program_counter = 10'($random(seed));
      exec({`MCX_OP_REQI, 1'b0, 2'(i)});
      check("irq id", {14'h0000, soft_irq_number}, 16'(i));
      reg_addr = `MCX_ADDR_IRQRET_A;
      hw_irq_req = 1'b1;
      #1;
      check("irq ret", {6'h00, reg_rdata[9:0]}, {6'h00, program_counter});
      check("hw held", {15'h0000, hw_irq_accept}, 16'h0000);
      exp_q.push_back(program_counter + 10'h001);
      irq_handler_done = 1'b1;
      tick;
      irq_handler_done = 1'b0;
      tick;
      check("hw free", {15'h0000, hw_irq_accept}, 16'h0001);
      hw_irq_req = 1'b0;
      tick;
    end
    return_link = 10'($random(seed));
    exp_q.push_back(return_link);
    exec(`MCX_OP_RFS);
    tick;
    exec({`MCX_OP_NOT, 3'h1});
    check("masks", {14'h0, mask_all_ones_flag, mask_zero_flag}, 16'h0002);
    for (int k = 0; k < 2; k++) begin
      n = 4'($random(seed));
      pe = (k == 1) ? 32'h0000FFFF * 32'(n) : 32'h0;
      exec({`MCX_OP_MULI, n, 3'(k)});
      stall(17, "mul stall");
      check("mul done", {15'h0000, operation_done_flag}, 16'h0001);
      check("mul hi", product_high_half, pe[31:16]);
      check("mul lo", product_low_half, pe[15:0]);
    end
    for (int k = 0; k < 4; k++) begin
      n = 4'(k * 4 + 1);
      exec({`MCX_OP_SHL_CONST, n, `MCX_OP_SH_TAIL});
      stall(int'(n), "shift stall");
    end
    check("shl ovf", {15'h0, shift_overflow_flag}, {15'h0, |pe[31:4]});
    pe = pe << 28;
    check("shl hi", product_high_half, pe[31:16]);
    check("shl lo", product_low_half, pe[15:0]);
    check("loads left", 16'(exp_q.size()), 16'h0000);
    tally_and_finish;
  end
endmodule
bind mcx_exec mcx_exec_sva #(.PC_W(PC_W)) u_sva (.clk_sys(clk_sys),
  .reset_n(reset_n), .instr_word(instr_word), .instr_valid(instr_valid),
  .instr_ready(instr_ready), .return_link(return_link),
  .pc_load_value(pc_load_value), .pc_load(pc_load),
  .hw_irq_accept(hw_irq_accept), .irq_handler_done(irq_handler_done),
  .soft_irq_active_q(soft_irq_active_q), .soft_irq_number(soft_irq_number),
  .soft_irq_pulse(soft_irq_pulse), .spi_address(spi_address),
  .spi_address_write(spi_address_write),
  .backdoor_read_pulse(backdoor_read_pulse), .backdoor_addr(backdoor_addr),
  .backdoor_corrupt(backdoor_corrupt),
  .operation_done_flag(operation_done_flag));
`default_nettype wire
